/* File: core/wide_regs_pkg.sv */
// package for the wide-mode architectural register file
// assumes the decode/execute pipeline of the core drives all ports
package wide_regs_pkg;
   localparam int unsigned INT_REG_COUNT = 16;
   localparam int unsigned INT_REG_WIDTH = 64;
   localparam int unsigned INT_IDX_WIDTH = 4;
   localparam int unsigned VEC_REG_COUNT = 16;
   localparam int unsigned VEC_REG_WIDTH = 128;
   localparam int unsigned CTRL_REG_COUNT = 5;
   localparam int unsigned CTRL_IDX_WIDTH = 3;
   localparam int unsigned DBG_REG_COUNT = 8;
   localparam int unsigned DBG_IDX_WIDTH = 3;
   localparam int unsigned LEGACY_FLAGS_WIDTH = 32;
   localparam int unsigned TABLE_LIMIT_WIDTH = 16;
   localparam int unsigned TASK_LEVEL_WIDTH = 4;
   localparam int unsigned PHYS_ADDR_WIDTH = 46;
   localparam int unsigned LEGACY_PHYS_WIDTH = 36;
   localparam int unsigned FLAT_ADDR_WIDTH = 32;
   localparam int unsigned REAL_LIN_WIDTH = 20;
   localparam int unsigned REAL_SEG_WIDTH = 16;
   localparam int unsigned REAL_SEG_SHIFT = 4;
   localparam int unsigned SELECTOR_WIDTH = 16;
   localparam int unsigned SEG_INDEX_WIDTH = 14;
   localparam int unsigned SEG_COUNT_MAX = 16383;
   localparam logic [63:0] FLAGS_RESET = 64'h0000_0000_0000_0002;
   localparam logic [63:0] FLAGS_LEGACY_MASK = 64'h0000_0000_ffff_ffff;
   localparam logic [63:0] IP_RESET = 64'h0000_0000_0000_fff0;
   localparam logic [63:0] BYTE_MASK = 64'h0000_0000_0000_00ff;
   localparam logic [63:0] WORD_MASK = 64'h0000_0000_0000_ffff;
   localparam logic [63:0] DWORD_MASK = 64'h0000_0000_ffff_ffff;
   localparam logic [63:0] QWORD_MASK = 64'hffff_ffff_ffff_ffff;

   typedef enum logic [1:0] {
      SIZE_BYTE, SIZE_WORD, SIZE_DWORD, SIZE_QWORD
   } op_size_e;

   typedef enum logic [1:0] {
      MODEL_WIDE, MODEL_FLAT, MODEL_SEGMENTED, MODEL_REAL
   } mem_model_e;

   typedef enum logic [2:0] {
      SYS_NONE, SYS_CTRL, SYS_TASK_LEVEL, SYS_DEBUG,
      SYS_GLOBAL, SYS_INTR, SYS_LOCAL, SYS_TASK
   } sys_target_e;

   // integer register write request
   typedef struct packed {
      logic en;
      logic [3:0] idx;
      op_size_e size;
      logic [63:0] data;
   } int_write_s;

   // descriptor-table base/limit pair: 10 bytes for the global and
   // interrupt tables
   typedef struct packed {
      logic [63:0] base;
      logic [15:0] limit;
   } table_reg_s;

   // address translation request
   typedef struct packed {
      logic en;
      mem_model_e model;
      logic [15:0] selector;
      logic [63:0] offset;
      logic [63:0] seg_base;
      logic [31:0] seg_limit;
   } xlate_req_s;

   typedef struct packed {
      logic valid;
      logic fault;
      logic [63:0] linear;
      logic [45:0] physical;
   } xlate_rsp_s;
endpackage : wide_regs_pkg

/* File: core/wide_mode_arch_register_file.sv */
// wide-mode architectural register file with address-model limits
// assumes one clock shared with decode/execute and synchronous inputs
`timescale 1ns/1ps

// How it works
// - sixteen 64-bit integer registers, byte to quadword sized access
// - byte accesses use bits 7:0 of every register, except writes to the stack pointer
// - instruction pointer held as full 64-bit value
// - 64-bit flags; low 32 legacy behaviour, upper 32 reserved
// - sixteen vector data registers for packed operations
// - stack pointer always 64 bits, no write size override honoured
// - control registers 64 bits plus task-priority control register
// - all debug registers are 64 bits wide
// - global/interrupt table registers 10 bytes; local/task 64-bit base
// - wide mode: 64-bit linear, 46-bit physical address space
// - byte-addressed physical memory; legacy range limited to 36 bits
// - flat model: one contiguous 32-bit linear space
// - segmented: selector plus offset translated, 16383 segments max
// - real model: 64 KB segments, 20-bit linear space
module wide_mode_arch_register_file #(
   parameter int unsigned INT_REGS = wide_regs_pkg::INT_REG_COUNT,
   parameter int unsigned VEC_REGS = wide_regs_pkg::VEC_REG_COUNT,
   parameter int unsigned PHYS_BITS = wide_regs_pkg::PHYS_ADDR_WIDTH
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_wide_mode,
   input wire logic [3:0] i_int_rd_idx,
   input wire wide_regs_pkg::op_size_e i_int_rd_size,
   input wire wide_regs_pkg::int_write_s i_int_wr,
   input wire logic [3:0] i_vec_rd_idx,
   input wire logic i_vec_wr_en,
   input wire logic [3:0] i_vec_wr_idx,
   input wire logic [127:0] i_vec_wr_data,
   input wire logic i_ip_wr_en,
   input wire logic [63:0] i_ip_wr_data,
   input wire logic i_flags_wr_en,
   input wire logic [63:0] i_flags_wr_data,
   input wire wide_regs_pkg::sys_target_e i_sys_wr_target,
   input wire logic [2:0] i_sys_wr_idx,
   input wire logic [63:0] i_sys_wr_base,
   input wire logic [15:0] i_sys_wr_limit,
   input wire wide_regs_pkg::sys_target_e i_sys_rd_target,
   input wire logic [2:0] i_sys_rd_idx,
   input wire wide_regs_pkg::xlate_req_s i_xlate,
   output logic [63:0] o_int_rd_data,
   output logic [63:0] o_stack_pointer,
   output logic [127:0] o_vec_rd_data,
   output logic [63:0] o_ip,
   output logic [63:0] o_flags,
   output logic [63:0] o_sys_rd_base,
   output logic [15:0] o_sys_rd_limit,
   output logic [3:0] o_task_priority_level,
   output wide_regs_pkg::xlate_rsp_s o_xlate
);
   // the stack pointer lives in integer slot four
   localparam logic [3:0] STACK_IDX = 4'h4;

   // =========================================================
   // state
   // =========================================================
   typedef struct packed {
      logic [INT_REGS-1:0][63:0] integer_registers;
      logic [VEC_REGS-1:0][127:0] vector_data_registers;
      logic [63:0] ip;
      logic [63:0] wide_flags_register;
      logic [wide_regs_pkg::CTRL_REG_COUNT-1:0][63:0] ctrl;
      logic [63:0] task_priority_control_register;
      logic [wide_regs_pkg::DBG_REG_COUNT-1:0][63:0] dbg;
      wide_regs_pkg::table_reg_s global_table_base_register;
      wide_regs_pkg::table_reg_s interrupt_table_base_register;
      wide_regs_pkg::table_reg_s local_table_base_register;
      wide_regs_pkg::table_reg_s task_state_base_register;
      logic [63:0] int_rd;
      logic [127:0] vec_rd;
      logic [63:0] sys_base;
      logic [15:0] sys_limit;
      wide_regs_pkg::xlate_rsp_s xlate;
   } state_s;

   // one register image; the next copy is filled combinationally
   state_s state_r;
   state_s state_nxt;

   // =========================================================
   // helpers
   // =========================================================
   // mask for an operand size; byte always means the lowest lane
   function automatic logic [63:0] size_mask(
      input wide_regs_pkg::op_size_e sz);
      case (sz)
         wide_regs_pkg::SIZE_BYTE: size_mask = wide_regs_pkg::BYTE_MASK;
         wide_regs_pkg::SIZE_WORD: size_mask = wide_regs_pkg::WORD_MASK;
         wide_regs_pkg::SIZE_DWORD: size_mask = wide_regs_pkg::DWORD_MASK;
         default: size_mask = wide_regs_pkg::QWORD_MASK;
      endcase
   endfunction : size_mask

   // merge of sized write into old value; dword writes zero the top half
   function automatic logic [63:0] merge_write(
      input logic [63:0] old_val,
      input logic [63:0] new_val,
      input wide_regs_pkg::op_size_e sz);
      logic [63:0] m;
      m = size_mask(sz);
      if (sz == wide_regs_pkg::SIZE_DWORD) begin
         merge_write = new_val & m;
      end else begin
         merge_write = (old_val & ~m) | (new_val & m);
      end
   endfunction : merge_write

   // =========================================================
   // next-state logic
   // =========================================================
   always_comb begin
      logic [63:0] lin;
      logic [63:0] off;
      logic flt;
      // scratch values for the translation path, cleared every pass
      lin = '0;
      off = '0;
      flt = 1'b0;
      state_nxt = state_r;

      // integer write; stack pointer is a full register, no override
      if (i_int_wr.en) begin
         if (i_int_wr.idx == STACK_IDX) begin
            state_nxt.integer_registers[i_int_wr.idx] =
               i_int_wr.data;
         end else begin
            state_nxt.integer_registers[i_int_wr.idx] = merge_write(
               state_r.integer_registers[i_int_wr.idx],
               i_int_wr.data, i_int_wr.size);
         end
      end
      // read port samples the old image: a write shows up next cycle
      state_nxt.int_rd = state_r.integer_registers[i_int_rd_idx]
         & size_mask(i_int_rd_size);

      // vector registers
      if (i_vec_wr_en) begin
         state_nxt.vector_data_registers[i_vec_wr_idx] =
            i_vec_wr_data;
      end
      // vector read port, same one-cycle timing as the integer port
      state_nxt.vec_rd = state_r.vector_data_registers[i_vec_rd_idx];

      // instruction pointer: outside wide mode the top half is cleared
      if (i_ip_wr_en) begin
         if (i_wide_mode) begin
            state_nxt.ip = i_ip_wr_data;
         end else begin
            state_nxt.ip = i_ip_wr_data & wide_regs_pkg::DWORD_MASK;
         end
      end

      // flags: reserved upper half can never be set
      if (i_flags_wr_en) begin
         state_nxt.wide_flags_register = i_flags_wr_data
            & wide_regs_pkg::FLAGS_LEGACY_MASK;
      end

      // system register writes, 64-bit wide except the task-priority level (bits 3:0 only)
      case (i_sys_wr_target)
         wide_regs_pkg::SYS_CTRL: begin
            if (i_sys_wr_idx < 3'(wide_regs_pkg::CTRL_REG_COUNT)) begin
               state_nxt.ctrl[i_sys_wr_idx] = i_sys_wr_base;
            end
         end
         wide_regs_pkg::SYS_TASK_LEVEL: begin
            state_nxt.task_priority_control_register =
               {60'h0, i_sys_wr_base[3:0]};
         end
         wide_regs_pkg::SYS_DEBUG: begin
            state_nxt.dbg[i_sys_wr_idx] = i_sys_wr_base;
         end
         wide_regs_pkg::SYS_GLOBAL: begin
            state_nxt.global_table_base_register =
               {i_sys_wr_base, i_sys_wr_limit};
         end
         wide_regs_pkg::SYS_INTR: begin
            state_nxt.interrupt_table_base_register =
               {i_sys_wr_base, i_sys_wr_limit};
         end
         wide_regs_pkg::SYS_LOCAL: begin
            state_nxt.local_table_base_register =
               {i_sys_wr_base, i_sys_wr_limit};
         end
         wide_regs_pkg::SYS_TASK: begin
            state_nxt.task_state_base_register =
               {i_sys_wr_base, i_sys_wr_limit};
         end
         default: begin
         end
      endcase

      // system register read port, registered
      state_nxt.sys_limit = '0;
      case (i_sys_rd_target)
         wide_regs_pkg::SYS_CTRL: begin
            if (i_sys_rd_idx < 3'(wide_regs_pkg::CTRL_REG_COUNT)) begin
               state_nxt.sys_base = state_r.ctrl[i_sys_rd_idx];
            end else begin
               state_nxt.sys_base = '0;
            end
         end
         wide_regs_pkg::SYS_TASK_LEVEL:
            state_nxt.sys_base = state_r.task_priority_control_register;
         wide_regs_pkg::SYS_DEBUG:
            state_nxt.sys_base = state_r.dbg[i_sys_rd_idx];
         wide_regs_pkg::SYS_GLOBAL: begin
            state_nxt.sys_base = state_r.global_table_base_register.base;
            state_nxt.sys_limit = state_r.global_table_base_register.limit;
         end
         wide_regs_pkg::SYS_INTR: begin
            state_nxt.sys_base = state_r.interrupt_table_base_register.base;
            state_nxt.sys_limit =
               state_r.interrupt_table_base_register.limit;
         end
         wide_regs_pkg::SYS_LOCAL: begin
            state_nxt.sys_base = state_r.local_table_base_register.base;
            state_nxt.sys_limit = state_r.local_table_base_register.limit;
         end
         wide_regs_pkg::SYS_TASK: begin
            state_nxt.sys_base = state_r.task_state_base_register.base;
            state_nxt.sys_limit = state_r.task_state_base_register.limit;
         end
         default: state_nxt.sys_base = '0;
      endcase

      // address translation per memory model; one cycle latency
      off = i_xlate.offset;
      case (i_xlate.model)
         wide_regs_pkg::MODEL_WIDE: begin
            lin = off;
            flt = ~i_wide_mode;
         end
         wide_regs_pkg::MODEL_FLAT: begin
            lin = off;
            flt = (off >> wide_regs_pkg::FLAT_ADDR_WIDTH) != '0;
         end
         wide_regs_pkg::MODEL_SEGMENTED: begin
            // index field zero is the null selector: not a usable segment
            flt = (i_xlate.selector[15:3] == '0)
               || (off[63:32] != '0)
               || (off[31:0] > i_xlate.seg_limit);
            lin = (i_xlate.seg_base + off) & wide_regs_pkg::DWORD_MASK;
         end
         wide_regs_pkg::MODEL_REAL: begin
            flt = (off >> wide_regs_pkg::REAL_SEG_WIDTH) != '0;
            lin = (({48'h0, i_xlate.selector}
               << wide_regs_pkg::REAL_SEG_SHIFT) + off)
               & ((64'h1 << wide_regs_pkg::REAL_LIN_WIDTH) - 64'h1);
         end
         default: begin
            flt = 1'b1;
         end
      endcase
      // physical width: byte addresses, 46 bits wide or 36 bits legacy
      if (i_wide_mode) begin
         if ((lin >> PHYS_BITS) != '0 &&
             i_xlate.model != wide_regs_pkg::MODEL_WIDE) begin
            flt = 1'b1;
         end
         state_nxt.xlate.physical = lin[45:0];
      end else begin
         state_nxt.xlate.physical = {10'h0,
            lin[wide_regs_pkg::LEGACY_PHYS_WIDTH-1:0]};
      end
      // result qualifiers; a fault only counts with a live request
      state_nxt.xlate.valid = i_xlate.en;
      state_nxt.xlate.fault = i_xlate.en & flt;
      state_nxt.xlate.linear = lin;
   end

   // =========================================================
   // registers
   // =========================================================
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r <= '0;
         // ip and flags start from their architectural reset values
         state_r.ip <= wide_regs_pkg::IP_RESET;
         state_r.wide_flags_register <= wide_regs_pkg::FLAGS_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   // outputs straight from state flops
   assign o_int_rd_data = state_r.int_rd;
   assign o_stack_pointer = state_r.integer_registers[STACK_IDX];
   assign o_vec_rd_data = state_r.vec_rd;
   assign o_ip = state_r.ip;
   assign o_flags = state_r.wide_flags_register;
   assign o_sys_rd_base = state_r.sys_base;
   assign o_sys_rd_limit = state_r.sys_limit;
   assign o_task_priority_level = state_r.task_priority_control_register[3:0];
   assign o_xlate = state_r.xlate;
endmodule : wide_mode_arch_register_file

/* File: sim/wide_mode_arch_register_file_checker.sv */
// assertions on the ports of the wide-mode register file
// assumes one clock domain; bound to the top module below
`timescale 1ns/1ps
// ============================================================
// port checker
module wide_mode_arch_register_file_checker (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [3:0] i_int_rd_idx,
   input wire wide_regs_pkg::op_size_e i_int_rd_size,
   input wire wide_regs_pkg::int_write_s i_int_wr,
   input wire logic i_flags_wr_en,
   input wire logic [63:0] i_flags_wr_data,
   input wire wide_regs_pkg::sys_target_e i_sys_rd_target,
   input wire logic [2:0] i_sys_rd_idx,
   input wire wide_regs_pkg::xlate_req_s i_xlate,
   input wire logic [63:0] o_int_rd_data,
   input wire logic [63:0] o_stack_pointer,
   input wire logic [63:0] o_flags,
   input wire logic [63:0] o_sys_rd_base,
   input wire wide_regs_pkg::xlate_rsp_s o_xlate
);
   logic [19:0] real_lin;
   logic rq;
   // real model wraps at 20 bits, so the sum is kept that narrow
   assign real_lin = {i_xlate.selector, 4'h0} + i_xlate.offset[19:0];
   assign rq = i_xlate.en && i_xlate.model == wide_regs_pkg::MODEL_REAL;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_flags_upper_zero: assert property (o_flags[63:32] == 32'h0)
      else $error("reserved flag bits not zero");
   a_flags_low_write: assert property (i_flags_wr_en ##1 !i_flags_wr_en
      |=> o_flags[31:0] == $past(i_flags_wr_data[31:0], 2))
      else $error("legacy flag bits not written");
   a_byte_read_mask: assert property (i_int_rd_size ==
      wide_regs_pkg::SIZE_BYTE |=> o_int_rd_data[63:8] == 56'h0)
      else $error("byte read not masked");
   a_byte_lane_low: assert property (i_int_wr.en ##1 (!i_int_wr.en &&
      i_int_rd_idx == $past(i_int_wr.idx))
      |=> o_int_rd_data[7:0] == $past(i_int_wr.data[7:0], 2))
      else $error("low byte lane lost");
   a_stack_full_width: assert property (i_int_wr.en &&
      i_int_wr.idx == 4'h4 ##1 !i_int_wr.en
      |=> o_stack_pointer == $past(i_int_wr.data, 2))
      else $error("stack pointer not full width");
   a_xlate_one_pulse: assert property (
      o_xlate.valid == $past(i_xlate.en))
      else $error("translation valid mistimed");
   a_real_linear_sum: assert property (rq &&
      i_xlate.offset < 64'h10000
      |=> !o_xlate.fault && o_xlate.linear == {44'h0, $past(real_lin)})
      else $error("real model linear address wrong");
   a_real_seg_fault: assert property (rq &&
      i_xlate.offset >= 64'h10000 |=> o_xlate.fault)
      else $error("real segment overrun not faulted");
   a_flat_range_fault: assert property (i_xlate.en &&
      i_xlate.model == wide_regs_pkg::MODEL_FLAT &&
      i_xlate.offset[63:32] != 32'h0 |=> o_xlate.fault)
      else $error("flat overrun not faulted");
   a_ctrl_spare_zero: assert property (i_sys_rd_target ==
      wide_regs_pkg::SYS_CTRL && i_sys_rd_idx >= 3'h5
      |=> o_sys_rd_base == 64'h0)
      else $error("spare control index not zero");
   c_real_xlate: cover property (rq ##1 o_xlate.valid);
   c_stack_write: cover property (i_int_wr.en && i_int_wr.idx == 4'h4);
   c_flags_write: cover property (i_flags_wr_en);
endmodule : wide_mode_arch_register_file_checker

bind wide_mode_arch_register_file wide_mode_arch_register_file_checker chk (
   .i_clk(i_clk), .i_rst(i_rst), .i_int_rd_idx(i_int_rd_idx),
   .i_int_rd_size(i_int_rd_size), .i_int_wr(i_int_wr),
   .i_flags_wr_en(i_flags_wr_en), .i_flags_wr_data(i_flags_wr_data),
   .i_sys_rd_target(i_sys_rd_target), .i_sys_rd_idx(i_sys_rd_idx),
   .i_xlate(i_xlate), .o_int_rd_data(o_int_rd_data),
   .o_stack_pointer(o_stack_pointer), .o_flags(o_flags),
   .o_sys_rd_base(o_sys_rd_base), .o_xlate(o_xlate));

/* File: sim/wide_mode_arch_register_file_tb.sv */
// self-checking bench for the wide-mode register file
// assumes the checker is bound on its own; expectations are queued
`timescale 1ns/1ps
// ============================================================
// bench
module wide_mode_arch_register_file_tb;
   typedef struct {int due; int sel; logic [127:0] exp;
      logic [127:0] msk;} note_s;
   logic i_clk, i_rst, i_wide_mode, i_vec_wr_en, i_ip_wr_en, i_flags_wr_en;
   logic [3:0] i_int_rd_idx, i_vec_rd_idx, i_vec_wr_idx;
   wide_regs_pkg::op_size_e i_int_rd_size;
   wide_regs_pkg::int_write_s i_int_wr;
   logic [127:0] i_vec_wr_data, o_vec_rd_data, seen;
   logic [63:0] i_ip_wr_data, i_flags_wr_data, i_sys_wr_base, d;
   wide_regs_pkg::sys_target_e i_sys_wr_target, i_sys_rd_target;
   logic [2:0] i_sys_wr_idx, i_sys_rd_idx;
   logic [15:0] i_sys_wr_limit, o_sys_rd_limit;
   wide_regs_pkg::xlate_req_s i_xlate;
   logic [63:0] o_int_rd_data, o_stack_pointer, o_ip, o_flags, o_sys_rd_base;
   logic [3:0] o_task_priority_level;
   wide_regs_pkg::xlate_rsp_s o_xlate;
   note_s q[$];
   logic [63:0] im [16];
   logic [127:0] vm [16];
   logic [31:0] r;
   logic [1:0] s;
   bit wi, wv;
   int cyc, num_errors, num_checks, seed;
   string nm [6] = '{"int_rd", "vec_rd", "sys_base", "sys_limit",
      "xlate", "tpl"};

   wide_mode_arch_register_file uut (.*);

   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   task automatic check(string n, logic [127:0] sn, logic [127:0] ex);
      num_checks++;
      if (sn !== ex) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, ex, sn);
      end
   endtask : check

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test

   // result is registered: visible one edge after the note is made, when cyc has counted two
   task automatic note(int sl, logic [127:0] ex, logic [127:0] mk = '1);
      q.push_back('{cyc + 2, sl, ex, mk});
   endtask : note

   // one edge; strobes set here, data fields by the caller
   task automatic step(bit xe = 0, iw = 0, vw = 0, ipw = 0, fw = 0,
      wide_regs_pkg::sys_target_e st = wide_regs_pkg::SYS_NONE);
      @(posedge i_clk);
      i_xlate.en <= xe;
      i_int_wr.en <= iw;
      i_vec_wr_en <= vw;
      i_ip_wr_en <= ipw;
      i_flags_wr_en <= fw;
      i_sys_wr_target <= st;
   endtask : step

   function automatic logic [63:0] sm(logic [1:0] z);
      return z == 0 ? 64'hff : z == 1 ? 64'hffff :
         z == 2 ? 64'hffff_ffff : '1;
   endfunction : sm

   function automatic logic [127:0] pick(int sl);
      case (sl)
         0: return {64'h0, o_int_rd_data};
         1: return o_vec_rd_data;
         2: return {64'h0, o_sys_rd_base};
         3: return {112'h0, o_sys_rd_limit};
         4: return {16'h0, o_xlate};
         default: return {124'h0, o_task_priority_level};
      endcase
   endfunction : pick

   // faults leave the address undefined, so only valid and fault count
   task automatic xl(logic [1:0] m, logic [15:0] sl, logic [63:0] o, b,
      logic [31:0] l, bit f, logic [63:0] lin);
      step(1);
      i_xlate.model <= wide_regs_pkg::mem_model_e'(m);
      i_xlate.selector <= sl;
      i_xlate.offset <= o;
      i_xlate.seg_base <= b;
      i_xlate.seg_limit <= l;
      note(4, {1'b1, f, lin, lin[45:0] & {{10{i_wide_mode}}, 36'hf_ffff_ffff}},
         f ? {16'h0, 2'b11, 110'h0} : '1);
   endtask : xl

   // compare every note falling due in this cycle, oldest first
   always @(negedge i_clk) begin
      while (q.size() > 0 && q[0].due == cyc) begin
         seen = pick(q[0].sel) & q[0].msk;
         check(nm[q[0].sel], seen, q[0].exp & q[0].msk);
         void'(q.pop_front());
      end
   end

   // cycle count doubles as the hang limit
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc > 3000) begin
         num_errors++;
         stop_test();
      end
   end

   initial begin
      seed = 32'hf0c66939;
      i_rst = 1'b1;
      i_int_wr = '0;
      i_xlate = '0;
      i_int_rd_size = wide_regs_pkg::SIZE_BYTE;
      i_sys_wr_target = wide_regs_pkg::SYS_NONE;
      i_sys_rd_target = wide_regs_pkg::SYS_NONE;
      {i_wide_mode, i_int_rd_idx, i_vec_rd_idx, i_vec_wr_en, i_vec_wr_idx,
         i_vec_wr_data, i_ip_wr_en, i_ip_wr_data, i_flags_wr_en,
         i_flags_wr_data, i_sys_wr_idx, i_sys_wr_base, i_sys_wr_limit,
         i_sys_rd_idx} = '0;
      // clock settling at time zero looks like a fall, so wait for a rise
      @(posedge i_clk);
      #1;
      check("ip_reset", o_ip, wide_regs_pkg::IP_RESET);
      check("flags_reset", o_flags, wide_regs_pkg::FLAGS_RESET);
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      i_wide_mode <= 1'b1;
      // fill all registers, then random back-to-back writes and reads
      for (int n = 0; n < 400; n++) begin
         r = $random(seed);
         d = {$random(seed), $random(seed)};
         s = (n < 16) ? 2'h3 : r[7:6];
         wi = n < 16 || r[4];
         wv = n < 16 || r[5];
         step(0, wi, wv);
         i_int_wr.idx <= (n < 16) ? n[3:0] : r[3:0];
         i_int_wr.size <= wide_regs_pkg::op_size_e'(s);
         i_int_wr.data <= d;
         i_vec_wr_idx <= (n < 16) ? n[3:0] : r[3:0];
         i_vec_wr_data <= {d, ~d};
         i_int_rd_idx <= r[11:8];
         i_int_rd_size <= wide_regs_pkg::op_size_e'(r[13:12]);
         i_vec_rd_idx <= r[11:8];
         if (n >= 16) begin
            note(0, im[r[11:8]] & sm(r[13:12]));
            note(1, vm[r[11:8]]);
         end
         if (n < 16) r[3:0] = n[3:0];
         if (wi) im[r[3:0]] = (r[3:0] == 4'h4) ? d : s[1] ? d & sm(s) :
            (im[r[3:0]] & ~sm(s)) | (d & sm(s));
         if (wv) vm[r[3:0]] = {d, ~d};
      end
      step();
      step();
      #1;
      check("stack_pointer", o_stack_pointer, im[4]);
      $display("test integer and vector registers done");
      // ip and flags, in and out of wide mode
      for (int n = 0; n < 4; n++) begin
         d = {$random(seed), $random(seed)};
         step(0, 0, 0, 1, 1);
         i_wide_mode <= ~n[0];
         i_ip_wr_data <= d;
         i_flags_wr_data <= (d & 64'hffff_ffff_003f_7fd5) | 64'h2;
         step();
         step();
         #1;
         check("ip", o_ip, n[0] ? {32'h0, d[31:0]} : d);
         check("flags", o_flags[31:0], d[31:0] & 32'h003f_7fd5 | 32'h2);
         check("flags_top", o_flags[63:32], 32'h0);
      end
      $display("test ip and flags done");
      // every system target and index: write, then read back
      for (int t = 1; t < 8; t++) begin
         for (int i = 0; i < 8; i++) begin
            d = {$random(seed), $random(seed)};
            step(0, 0, 0, 0, 0, wide_regs_pkg::sys_target_e'(t));
            i_sys_wr_idx <= i[2:0];
            i_sys_wr_base <= d;
            i_sys_wr_limit <= d[31:16];
            step();
            i_sys_rd_target <= wide_regs_pkg::sys_target_e'(t);
            i_sys_rd_idx <= i[2:0];
            if (t == 2) note(5, d[3:0]);
            else note(2, (t == 1 && i > 4) ? 64'h0 : d);
            note(3, t > 3 ? d[31:16] : 16'h0);
         end
      end
      $display("test system registers done");
      // address models outside wide mode, then wide model refused
      step();
      i_wide_mode <= 1'b0;
      xl(3, 16'h1234, 64'h10, 0, 0, 0, 64'h12350);
      xl(3, 16'hffff, 64'hffff, 0, 0, 0, 64'h0ffef);
      xl(3, 16'h1234, 64'h10000, 0, 0, 1, 0);
      xl(1, 0, 64'hffff_ffff, 0, 0, 0, 64'hffff_ffff);
      xl(1, 0, 64'h1_0000_0000, 0, 0, 1, 0);
      xl(2, 16'h8, 64'h2000, 64'hffff_f000, '1, 0, 64'h1000);
      xl(2, 16'h8, 64'h101, 0, 32'h100, 1, 0);
      xl(2, 16'h0, 64'h10, 0, '1, 1, 0);
      xl(0, 0, 64'h10, 0, 0, 1, 0);
      for (int n = 0; n < 16; n++) begin
         r = $random(seed);
         xl(3, r[15:0], {48'h0, r[31:16]}, 0, 0, 0,
            {44'h0, {r[15:0], 4'h0} + {4'h0, r[31:16]}});
      end
      // wide mode: full 64-bit linear address, 46-bit physical
      step();
      i_wide_mode <= 1'b1;
      xl(0, 0, 64'hfedc_ba98_7654_3210, 0, 0, 0,
         64'hfedc_ba98_7654_3210);
      xl(1, 0, 64'h8000_0000, 0, 0, 0, 64'h8000_0000);
      repeat (3) step();
      $display("test address models done");
      stop_test();
   end
endmodule : wide_mode_arch_register_file_tb
